/* pin_remap_pkg.sv */
/*
  Constants and carrier types for the pin remap and debug port configuration block.
  Assumes one clock domain and package pins sampled synchronously to it.
*/
package pin_remap_pkg;

  // port codes used by the interrupt source selects
  localparam int PORT_NUM = 5;
  localparam logic [3:0] PORT_A = 4'h0;
  localparam logic [3:0] PORT_B = 4'h1;
  localparam int PINS_PER_PORT = 16;
  localparam int EXT_IRQ_LINES = 16;
  localparam int SEL_W = 4;
  localparam int LINES_PER_REG = 4;

  // pin numbers that the fixed mappings use
  localparam int PIN_0 = 0;
  localparam int PIN_3 = 3;
  localparam int PIN_15 = 15;
  localparam int ADC_TRIG_LINE = 11;

  // bit positions of the five debug pins in the release vector
  localparam int DBG_PA13 = 0;
  localparam int DBG_PA14 = 1;
  localparam int DBG_PA15 = 2;
  localparam int DBG_PB3 = 3;
  localparam int DBG_PB4 = 4;

  // debug port configuration codes
  localparam logic [2:0] DBG_FULL = 3'h0;
  localparam logic [2:0] DBG_NO_TAP_RST = 3'h1;
  localparam logic [2:0] DBG_SW_ONLY = 3'h2;
  localparam logic [2:0] DBG_OFF = 3'h4;

  // release patterns per code, trace pin handled separately
  localparam logic [4:0] REL_FULL = 5'h00;
  localparam logic [4:0] REL_NO_TAP_RST = 5'h10;
  localparam logic [4:0] REL_SW_ONLY = 5'h1C;
  localparam logic [4:0] REL_OFF = 5'h1F;

  // timer pin route codes
  localparam logic [1:0] TIM_NO_REMAP = 2'h0;
  localparam logic [1:0] TIM_PARTIAL1 = 2'h1;
  localparam logic [1:0] TIM_PARTIAL2 = 2'h2;
  localparam logic [1:0] TIM_FULL = 2'h3;

  // first remap configuration register
  typedef struct packed {
    logic [2:0] debug_port_config;
    logic adc0_trigger_route_sel;
    logic adc1_trigger_route_sel;
    logic [1:0] timer0_route;
    logic [1:0] timer1_route;
    logic [1:0] timer2_route;
    logic timer3_route;
    logic timer4_ch3_input_route;
  } remap0_t;

  // second remap configuration register
  typedef struct packed {
    logic timer8_route;
  } remap1_t;

  localparam remap0_t REMAP0_RST = '0;
  localparam remap1_t REMAP1_RST = '0;

  // debug port status carried out of the block
  typedef struct packed {
    logic jtag_en;
    logic swd_en;
    logic trace_on;
    logic [4:0] gpio_release;
  } dbg_status_t;

endpackage : pin_remap_pkg

/* peripheral_pin_remap_debug_cfg.sv */
/*
  Remap configuration, interrupt source selection and debug pin release logic.
  Assumes configuration strobes and pin levels are synchronous to mclk, and
  that the peripherals and pad logic consume the registered selections.
*/
// Contract
// - two remap registers pick pin functions
// - software picks each interrupt line's source pin
// - debug signals sit on five fixed pins
// - code 000 keeps all debug pins, reset value
// - code 001 releases only tap reset pin
// - code 010 drops jtag, releases three pins
// - code 100 disables debug, releases all pins
// - trace pin never released during async trace
// - reset: combined debug port on, trace off
// - converter 0 trigger: line 11 or timer 7
// - converter 1 trigger: line 11 or timer 7
// - timers 0-2 two-bit route, 3 and 8 one
// - timer 8 route lives in second register
// - timer 4 channel 3 from pin or oscillator
`timescale 1ns/100ps
module peripheral_pin_remap_debug_cfg (
  input wire logic mclk,
  input wire logic rst,
  input wire logic remap0_wr,
  input wire pin_remap_pkg::remap0_t remap0_wdata,
  input wire logic remap1_wr,
  input wire pin_remap_pkg::remap1_t remap1_wdata,
  input wire logic ext_irq_sel_wr,
  input wire logic [1:0] ext_irq_sel_idx,
  input wire logic [15:0] ext_irq_sel_wdata,
  input wire logic async_trace_req,
  input wire logic [4:0][15:0] pin_in,
  input wire logic timer7_trigger_out,
  input wire logic internal_40k_osc,
  output pin_remap_pkg::remap0_t remap_config_reg0_ff,
  output pin_remap_pkg::remap1_t remap_config_reg1_ff,
  output pin_remap_pkg::dbg_status_t dbg_status_ff,
  output logic debug_cfg_refused_ff,
  output logic [15:0] ext_irq_line_ff,
  output logic adc0_trigger_ff,
  output logic adc1_trigger_ff,
  output logic timer4_ch3_in_ff,
  output logic timer1_ch0_eti_in_ff
);

  logic [3:0] ext_irq_source_select_ff [pin_remap_pkg::EXT_IRQ_LINES];
  logic legal_code;
  logic [4:0] nxt_release;
  logic nxt_jtag;
  logic nxt_swd;

  // unlisted debug codes are refused so a stray write cannot lock out the debugger
  always_comb begin
    legal_code = (remap0_wdata.debug_port_config == pin_remap_pkg::DBG_FULL) ||
                 (remap0_wdata.debug_port_config == pin_remap_pkg::DBG_NO_TAP_RST) ||
                 (remap0_wdata.debug_port_config == pin_remap_pkg::DBG_SW_ONLY) ||
                 (remap0_wdata.debug_port_config == pin_remap_pkg::DBG_OFF);
  end

  // first remap register: debug field kept on a refused code, rest always taken
  always_ff @(posedge mclk) begin
    if (rst) begin
      remap_config_reg0_ff <= pin_remap_pkg::REMAP0_RST;
    end else if (remap0_wr) begin
      remap_config_reg0_ff <= remap0_wdata;
      if (!legal_code) begin
        remap_config_reg0_ff.debug_port_config <= remap_config_reg0_ff.debug_port_config;
      end
    end
  end

  // refused-write flag stands one cycle after the write
  always_ff @(posedge mclk) begin
    if (rst) begin
      debug_cfg_refused_ff <= 1'b0;
    end else begin
      debug_cfg_refused_ff <= remap0_wr && !legal_code;
    end
  end

  // second remap register holds only the timer 8 route
  always_ff @(posedge mclk) begin
    if (rst) begin
      remap_config_reg1_ff <= pin_remap_pkg::REMAP1_RST;
    end else if (remap1_wr) begin
      remap_config_reg1_ff <= remap1_wdata;
    end
  end

  // debug port decode; unknown codes cannot be stored, default keeps everything
  always_comb begin
    nxt_jtag = 1'b1;
    nxt_swd = 1'b1;
    nxt_release = pin_remap_pkg::REL_FULL;
    case (remap_config_reg0_ff.debug_port_config)
      pin_remap_pkg::DBG_FULL: begin
        nxt_release = pin_remap_pkg::REL_FULL;
      end
      pin_remap_pkg::DBG_NO_TAP_RST: begin
        nxt_release = pin_remap_pkg::REL_NO_TAP_RST;
      end
      pin_remap_pkg::DBG_SW_ONLY: begin
        nxt_jtag = 1'b0;
        nxt_release = pin_remap_pkg::REL_SW_ONLY;
      end
      pin_remap_pkg::DBG_OFF: begin
        nxt_jtag = 1'b0;
        nxt_swd = 1'b0;
        nxt_release = pin_remap_pkg::REL_OFF;
      end
      default: begin
        nxt_release = pin_remap_pkg::REL_FULL;
      end
    endcase
    // trace output overrides any release of its pin
    if (async_trace_req) begin
      nxt_release[pin_remap_pkg::DBG_PB3] = 1'b0;
    end
  end

  // both ports stay enabled together under codes 000 and 001 so the debugger can pick its own protocol
  always_ff @(posedge mclk) begin
    if (rst) begin
      dbg_status_ff <= '{jtag_en: 1'b1, swd_en: 1'b1, trace_on: 1'b0, gpio_release: pin_remap_pkg::REL_FULL};
    end else begin
      dbg_status_ff.jtag_en <= nxt_jtag;
      dbg_status_ff.swd_en <= nxt_swd;
      dbg_status_ff.trace_on <= async_trace_req;
      dbg_status_ff.gpio_release <= nxt_release;
    end
  end

  // interrupt source selects: four lines per write, one nibble each
  for (genvar i = 0; i < pin_remap_pkg::EXT_IRQ_LINES; i++) begin : g_line
    always_ff @(posedge mclk) begin
      if (rst) begin
        ext_irq_source_select_ff[i] <= pin_remap_pkg::PORT_A;
      end else if (ext_irq_sel_wr && (ext_irq_sel_idx == 2'(i / pin_remap_pkg::LINES_PER_REG))) begin
        ext_irq_source_select_ff[i] <=
          ext_irq_sel_wdata[(i % pin_remap_pkg::LINES_PER_REG) * pin_remap_pkg::SEL_W +: pin_remap_pkg::SEL_W];
      end
    end
    // a select beyond the last port reads as a quiet line
    always_ff @(posedge mclk) begin
      if (rst) begin
        ext_irq_line_ff[i] <= 1'b0;
      end else if (ext_irq_source_select_ff[i] < 4'(pin_remap_pkg::PORT_NUM)) begin
        ext_irq_line_ff[i] <= pin_in[3'(ext_irq_source_select_ff[i])][i];
      end else begin
        ext_irq_line_ff[i] <= 1'b0;
      end
    end
  end

  // converter triggers follow the registered line 11 or timer 7, adding one cycle of latency
  always_ff @(posedge mclk) begin
    if (rst) begin
      adc0_trigger_ff <= 1'b0;
      adc1_trigger_ff <= 1'b0;
    end else begin
      adc0_trigger_ff <= remap_config_reg0_ff.adc0_trigger_route_sel ? timer7_trigger_out :
                         ext_irq_line_ff[pin_remap_pkg::ADC_TRIG_LINE];
      adc1_trigger_ff <= remap_config_reg0_ff.adc1_trigger_route_sel ? timer7_trigger_out :
                         ext_irq_line_ff[pin_remap_pkg::ADC_TRIG_LINE];
    end
  end

  // timer input muxes; the shared channel 0 / trigger pin feeds one wire to both users
  always_ff @(posedge mclk) begin
    if (rst) begin
      timer4_ch3_in_ff <= 1'b0;
      timer1_ch0_eti_in_ff <= 1'b0;
    end else begin
      timer4_ch3_in_ff <= remap_config_reg0_ff.timer4_ch3_input_route ? internal_40k_osc :
                          pin_in[0][pin_remap_pkg::PIN_3];
      timer1_ch0_eti_in_ff <= remap_config_reg0_ff.timer1_route[0] ? pin_in[0][pin_remap_pkg::PIN_15] :
                              pin_in[0][pin_remap_pkg::PIN_0];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_REMAP_TAKES_WRITE: assert property (remap0_wr && legal_code |=> remap_config_reg0_ff == $past(remap0_wdata))
    else $error("remap register 0 did not take write");
  AST_REFUSED_CODE_KEPT: assert property (remap0_wr && !legal_code |=> $stable(remap_config_reg0_ff.debug_port_config))
    else $error("forbidden debug code was stored");
  AST_CODE_FULL: assert property (remap_config_reg0_ff.debug_port_config == pin_remap_pkg::DBG_FULL |=>
    dbg_status_ff.gpio_release == 5'h00 && dbg_status_ff.jtag_en && dbg_status_ff.swd_en)
    else $error("code 000 released a pin");
  AST_CODE_NO_TAP_RST: assert property (remap_config_reg0_ff.debug_port_config == pin_remap_pkg::DBG_NO_TAP_RST |=>
    dbg_status_ff.gpio_release == 5'h10 && dbg_status_ff.jtag_en)
    else $error("code 001 wrong release");
  AST_CODE_SW_ONLY: assert property (remap_config_reg0_ff.debug_port_config == pin_remap_pkg::DBG_SW_ONLY |=>
    dbg_status_ff.gpio_release[4] && dbg_status_ff.gpio_release[2] && !dbg_status_ff.gpio_release[1] &&
    dbg_status_ff.gpio_release[3] == !$past(async_trace_req) && !dbg_status_ff.jtag_en && dbg_status_ff.swd_en)
    else $error("code 010 wrong release");
  AST_CODE_OFF: assert property (remap_config_reg0_ff.debug_port_config == pin_remap_pkg::DBG_OFF |=>
    dbg_status_ff.gpio_release[2:0] == 3'h7 && !dbg_status_ff.swd_en && !dbg_status_ff.jtag_en)
    else $error("code 100 did not release all");
  AST_TRACE_HOLDS_PIN: assert property (dbg_status_ff.trace_on |-> !dbg_status_ff.gpio_release[3])
    else $error("trace pin released during trace");
  AST_RESET_STATE: assert property (@(posedge mclk) disable iff (1'b0) rst |=>
    remap_config_reg0_ff.debug_port_config == 3'h0 && !dbg_status_ff.trace_on)
    else $error("reset state wrong");
  AST_ADC0_ROUTE: assert property (!remap_config_reg0_ff.adc0_trigger_route_sel |=>
    adc0_trigger_ff == $past(ext_irq_line_ff[11]))
    else $error("converter 0 trigger not on line 11");
  AST_ADC1_ROUTE: assert property (remap_config_reg0_ff.adc1_trigger_route_sel |=>
    adc1_trigger_ff == $past(timer7_trigger_out))
    else $error("converter 1 trigger not on timer 7");
  AST_T4CH3_ROUTE: assert property (remap_config_reg0_ff.timer4_ch3_input_route |=>
    timer4_ch3_in_ff == $past(internal_40k_osc))
    else $error("timer 4 channel 3 not on oscillator");
  AST_EXT_IRQ_SEL: assert property (ext_irq_source_select_ff[11] == pin_remap_pkg::PORT_B |=>
    ext_irq_line_ff[11] == $past(pin_in[1][11]))
    else $error("line 11 not from port B");
  AST_REMAP1_WRITE: assert property (remap1_wr ##1 !remap1_wr [*2] |-> remap_config_reg1_ff == $past(remap1_wdata, 2))
    else $error("timer 8 route lost");

  COV_SW_ONLY: cover property (remap0_wr && remap0_wdata.debug_port_config == pin_remap_pkg::DBG_SW_ONLY ##2
    dbg_status_ff.gpio_release[2]);
  COV_REFUSED: cover property (remap0_wr && !legal_code ##1 debug_cfg_refused_ff);
  COV_TRACE_OFF_CODE: cover property (remap_config_reg0_ff.debug_port_config == pin_remap_pkg::DBG_OFF &&
    async_trace_req ##1 dbg_status_ff.trace_on);
  COV_ADC_TIMER7: cover property (remap_config_reg0_ff.adc0_trigger_route_sel ##1 adc0_trigger_ff);

endmodule : peripheral_pin_remap_debug_cfg

/* pin_pad_model.sv */
/*
  Pad and peripheral model for the remap block: pins, timer 7 trigger, oscillator.
  Assumes the bench's mclk and rst.
*/
`timescale 1ns/100ps
module pin_pad_model (
  input wire logic mclk,
  input wire logic rst,
  output logic [4:0][15:0] pin_in,
  output logic timer7_trigger_out,
  output logic internal_40k_osc
);
  logic [79:0] pads_ff;
  // the shared timer 1 pin carries one pad level; the timer 1 route picks pin 0 or pin 15 for both users
  assign pin_in = pads_ff;
  // pads change every cycle, so a stale or wrong pin pick cannot match for long
  always_ff @(posedge mclk) begin
    if (rst) begin
      pads_ff <= '0;
      timer7_trigger_out <= 1'b0;
      internal_40k_osc <= 1'b0;
    end else begin
      pads_ff <= {pads_ff[78:0], ~(pads_ff[79] ^ pads_ff[37])};
      timer7_trigger_out <= pads_ff[5] ^ pads_ff[60];
      internal_40k_osc <= ~internal_40k_osc; // runs free, faster than real
    end
  end
endmodule : pin_pad_model

/* peripheral_pin_remap_debug_cfg_test.sv */
/*
  Bench for the remap block: a shadow model built from the remap rules
  is compared with every output on every cycle after the first reset.
  Assumes the pad model drives pins, timer 7 trigger and oscillator.
*/
`timescale 1ns/100ps
module peripheral_pin_remap_debug_cfg_test;
  logic mclk, rst, remap0_wr, remap1_wr, ext_irq_sel_wr, async_trace_req, bad_code;
  pin_remap_pkg::remap0_t remap0_wdata, r0_ff, m_r0;
  pin_remap_pkg::remap1_t remap1_wdata, r1_ff, m_r1;
  pin_remap_pkg::dbg_status_t dbg_ff, m_dbg;
  logic [1:0] ext_irq_sel_idx;
  logic [15:0] ext_irq_sel_wdata, line_ff, m_line;
  logic [63:0] m_sel;
  logic [4:0][15:0] pin_in;
  logic timer7_trigger_out, internal_40k_osc, ref_ff, adc0_ff, adc1_ff, t4_ff, t1_ff;
  logic m_ref, m_adc0, m_adc1, m_t4, m_t1, chk_on;
  int n_mismatch, num_checks, seed, c;

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  peripheral_pin_remap_debug_cfg u_dut (.mclk(mclk), .rst(rst), .remap0_wr(remap0_wr),
    .remap0_wdata(remap0_wdata), .remap1_wr(remap1_wr), .remap1_wdata(remap1_wdata),
    .ext_irq_sel_wr(ext_irq_sel_wr), .ext_irq_sel_idx(ext_irq_sel_idx),
    .ext_irq_sel_wdata(ext_irq_sel_wdata), .async_trace_req(async_trace_req), .pin_in(pin_in),
    .timer7_trigger_out(timer7_trigger_out), .internal_40k_osc(internal_40k_osc),
    .remap_config_reg0_ff(r0_ff), .remap_config_reg1_ff(r1_ff), .dbg_status_ff(dbg_ff),
    .debug_cfg_refused_ff(ref_ff), .ext_irq_line_ff(line_ff), .adc0_trigger_ff(adc0_ff),
    .adc1_trigger_ff(adc1_ff), .timer4_ch3_in_ff(t4_ff), .timer1_ch0_eti_in_ff(t1_ff));

  pin_pad_model u_pads (.mclk(mclk), .rst(rst), .pin_in(pin_in),
    .timer7_trigger_out(timer7_trigger_out), .internal_40k_osc(internal_40k_osc));

  function automatic logic [4:0] rel_of(logic [2:0] code);
    case (code)
      3'h1: return 5'h10;
      3'h2: return 5'h1C;
      3'h4: return 5'h1F;
      default: return 5'h00;
    endcase
  endfunction : rel_of

  assign bad_code = remap0_wr && !(remap0_wdata.debug_port_config inside {3'h0, 3'h1, 3'h2, 3'h4});

  // shadow model: nonblocking updates give the same edge lag as the flops
  always @(posedge mclk) begin
    if (rst) begin
      {m_r0, m_r1, m_sel, m_ref, m_line, m_adc0, m_adc1, m_t4, m_t1} <= '0;
      m_dbg <= 8'hC0;
    end else begin
      if (remap0_wr) m_r0 <= remap0_wdata;
      if (bad_code) m_r0.debug_port_config <= m_r0.debug_port_config;
      if (remap1_wr) m_r1 <= remap1_wdata;
      if (ext_irq_sel_wr) m_sel[32'(ext_irq_sel_idx) * 16 +: 16] <= ext_irq_sel_wdata;
      m_ref <= bad_code;
      m_dbg <= {m_r0.debug_port_config[2:1] == 2'h0, m_r0.debug_port_config != 3'h4, async_trace_req,
        rel_of(m_r0.debug_port_config) & ~{1'b0, async_trace_req, 3'h0}};
      for (int i = 0; i < 16; i++) begin
        m_line[i] <= (m_sel[4*i +: 4] < 4'h5) ? pin_in[m_sel[4*i +: 4]][i] : 1'b0;
      end
      m_adc0 <= m_r0.adc0_trigger_route_sel ? timer7_trigger_out : m_line[11];
      m_adc1 <= m_r0.adc1_trigger_route_sel ? timer7_trigger_out : m_line[11];
      m_t4 <= m_r0.timer4_ch3_input_route ? internal_40k_osc : pin_in[0][3];
      m_t1 <= m_r0.timer1_route[0] ? pin_in[0][15] : pin_in[0][0];
    end
  end

  task automatic chk_vec(string what, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_vec

  task automatic chk_bit(string what, logic exp, logic got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  // outputs are settled by the falling edge
  always @(negedge mclk) begin
    if (chk_on) begin
      chk_vec("reg0", 16'(m_r0), 16'(r0_ff));
      chk_bit("reg1", m_r1, r1_ff);
      chk_vec("dbg", 16'(m_dbg), 16'(dbg_ff));
      chk_vec("dbg ports", 16'(m_dbg[7:6]), 16'(dbg_ff[7:6]));
      chk_bit("refused", m_ref, ref_ff);
      chk_vec("lines", m_line, line_ff);
      chk_bit("adc0", m_adc0, adc0_ff);
      chk_bit("adc1", m_adc1, adc1_ff);
      chk_bit("tim4", m_t4, t4_ff);
      chk_bit("tim1", m_t1, t1_ff);
    end
  end

  task automatic print_verdict();
    if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  // port codes 0..5, where 5 stands for the quiet codes
  function automatic logic [15:0] sel_word();
    logic [15:0] w;
    for (int j = 0; j < 4; j++) w[4*j +: 4] = 4'($unsigned($random(seed)) % 6);
    return w;
  endfunction : sel_word

  initial begin
    repeat (50000) @(posedge mclk);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    seed = 32'ha626;
    {rst, chk_on} = 2'h2;
    {remap0_wr, remap1_wr, ext_irq_sel_wr, async_trace_req} = 4'h0;
    {remap0_wdata, remap1_wdata, ext_irq_sel_idx, ext_irq_sel_wdata} = '0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    chk_on <= 1'b1;
    // every debug code, listed and forbidden, with and without trace
    for (c = 0; c < 16; c++) begin
      @(posedge mclk);
      remap0_wr <= 1'b1;
      remap0_wdata <= {3'(c), 10'($random(seed))};
      async_trace_req <= c[3];
      @(posedge mclk);
      remap0_wr <= 1'b0;
      repeat (3) @(posedge mclk);
    end
    // random traffic, back-to-back writes and a reset in mid-run
    for (c = 0; c < 1500; c++) begin
      @(posedge mclk);
      rst <= (c >= 700 && c < 703);
      remap0_wr <= 2'($random(seed)) == 2'h0;
      remap0_wdata <= 13'($random(seed));
      remap1_wr <= 1'($random(seed));
      remap1_wdata <= 1'($random(seed));
      ext_irq_sel_wr <= 1'($random(seed));
      ext_irq_sel_idx <= 2'($random(seed));
      ext_irq_sel_wdata <= sel_word();
      async_trace_req <= 3'($random(seed)) == 3'h0;
    end
    repeat (3) @(posedge mclk);
    print_verdict();
  end
endmodule : peripheral_pin_remap_debug_cfg_test
